/* src/lpm_pkg.sv */
// Purpose: shared constants and types of the low-power mode controller
// Assumes: 250 MHz ref_clk, byte addressed register port
// Notes: offsets are byte addresses of 32-bit words
package lpm_pkg;
	// ----------------------------------------------------------------
	// register map
	// ----------------------------------------------------------------
	localparam logic [7:0] OFS_CTRL = 8'h00;
	localparam logic [7:0] OFS_CLK = 8'h04;
	localparam logic [7:0] OFS_WAKE_EN = 8'h08;
	localparam logic [7:0] OFS_STATUS = 8'h0C;
	localparam logic [7:0] OFS_PVD_FLAG = 8'h10;
	localparam logic [7:0] OFS_WAKE_PEND = 8'h14;
	// ctrl fields
	localparam int CTRL_VR_LSB = 0;
	localparam int CTRL_DEEP = 2;
	localparam int CTRL_LPSLEEP = 3;
	localparam int CTRL_LPRUN = 4;
	localparam int CTRL_STBY = 5;
	localparam int CTRL_VREF_AUTO = 6;
	localparam int CTRL_VREF_EN = 7;
	localparam int CTRL_PVD_EN = 8;
	localparam int CTRL_PVD_LVL_LSB = 9;
	localparam int CTRL_PVD_EDGE_LSB = 12;
	localparam int CTRL_WIDTH = 14;
	localparam logic [13:0] CTRL_RST = 14'h0082;
	// clk fields
	localparam int CLK_SRC_LSB = 0;
	localparam int CLK_MSI_LSB = 2;
	localparam logic [4:0] CLK_RST = 5'h14;
	localparam logic [2:0] MSI_MIN_RANGE = 3'h1;
	// status fields
	localparam int ST_MODE_LSB = 0;
	localparam int ST_REG_LSB = 3;
	localparam int ST_BOOT_LSB = 5;
	localparam int ST_PVD = 7;
	localparam int ST_VR_LSB = 8;
	localparam int ST_STBYF = 10;
	// ----------------------------------------------------------------
	// voltage ranges, thresholds, timing
	// ----------------------------------------------------------------
	localparam logic [1:0] VR1 = 2'h1;
	localparam logic [1:0] VR2 = 2'h2;
	localparam logic [1:0] VR3 = 2'h3;
	localparam logic [5:0] FMAX_VR1_MHZ = 6'h20;
	localparam logic [5:0] FMAX_VR2_MHZ = 6'h10;
	localparam logic [5:0] FMAX_VR3_MHZ = 6'h04;
	localparam int BOR_LEVELS = 5;
	localparam int PVD_LEVELS = 7;
	localparam int CLK_MHZ = 250;
	localparam int WAKE_US = 8;
	localparam int WAKE_CYC = WAKE_US * CLK_MHZ;
	localparam int RST_HOLD_CYC = 8;
	localparam int SEQ_W = 12;
	// ----------------------------------------------------------------
	// types
	// ----------------------------------------------------------------
	typedef enum logic [2:0] {
		M_RUN, M_SLEEP, M_LP_RUN, M_LP_SLEEP, M_STOP, M_STOP_EXIT,
		M_STANDBY, M_STBY_EXIT
	} lpm_mode_t;
	typedef enum logic [1:0] {REG_MAIN, REG_LP, REG_OFF} lpm_reg_t;
	typedef enum logic [1:0] {BOOT_FLASH, BOOT_SYSMEM, BOOT_SRAM} lpm_boot_t;
	typedef enum logic [1:0] {SRC_MSI, SRC_HSI, SRC_HSE, SRC_PLL} lpm_src_t;
	typedef struct packed {
		logic rtc_wkup;
		logic rtc_stamp;
		logic rtc_tamper;
		logic usb;
		logic rtc_alarm;
		logic comp2;
		logic comp1;
		logic supply_voltage_detector;
		logic [15:0] ext;
	} lpm_wake_t;
	typedef struct packed {
		logic cpu;
		logic core;
		logic pll;
		logic multispeed_internal_osc;
		logic fast_internal_osc;
		logic fast_external_crystal;
		logic slow_osc;
	} lpm_clk_ctl_t;
endpackage : lpm_pkg

/* src/lpm_ctrl.sv */
// Purpose: power-mode sequencer, supply reset, voltage detector, boot strap
// Assumes: one 250 MHz clock, slow oscillator seen as a tick enable
// Notes: analog comparators arrive as asynchronous levels
//
// Decided for this implementation: the register addresses and the strobed register port.
`timescale 1ns/1ns
`default_nettype none

// Functional notes
// - three voltage ranges cap cpu clock at 32, 16, 4 MHz
// - lowest range forces system clock onto multispeed oscillator only
// - sleep stops cpu clock only; any peripheral event wakes it
// - low-power run uses minimum multispeed setting and low-power regulator
// - low-power sleep is sleep plus low-power regulator, restricted clocks
// - wake from low-power sleep returns to run with main regulator
// - stop gates core clocks, pll and fast oscillators; regulator low-power
// - stop keeps ram, registers, rtc; slow oscillator keeps running
// - any enabled wake line leaves stop within 8 us
// - stop wake sources: 16 lines, detector, comparators, rtc, usb
// - comparator wakes only count while reference voltage is on
// - brownout level picks one of five thresholds from option bits
// - optional automatic reference voltage switch-off during stop
// - held in reset while supply below power-on or brownout level
// - voltage detector has seven software-selected thresholds
// - detector interrupt on falling, rising or both crossings
// - regulator mode follows power mode: main, low-power, power-down
// - standby drops core registers and ram; wake logic is kept
// - boot pins select flash, system memory or embedded ram
// - system memory loader may use either serial port or usb
module lpm_ctrl #(
	parameter int SLOW_DIV = 256,
	parameter int OSC_RESTART_CYC = 16
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire logic core_sleep_req,
	input wire logic periph_evt,
	input wire lpm_pkg::lpm_wake_t wake_src,
	input wire logic por_low,
	input wire logic [lpm_pkg::BOR_LEVELS-1:0] bor_cmp,
	input wire logic [2:0] bor_level_opt,
	input wire logic [lpm_pkg::PVD_LEVELS-1:0] pvd_cmp,
	input wire logic [1:0] boot_pins,
	output lpm_pkg::lpm_clk_ctl_t clk_ctl,
	output lpm_pkg::lpm_src_t sysclk_sel,
	output logic [2:0] msi_range,
	output logic [5:0] cpu_fmax_mhz,
	output logic [1:0] vcore_range,
	output lpm_pkg::lpm_reg_t reg_mode,
	output logic periph_limit,
	output logic ram_retain,
	output logic core_pwr_en,
	output logic internal_reference_voltage_en,
	output logic sys_reset,
	output lpm_pkg::lpm_boot_t boot_src,
	output logic [2:0] loader_port_en,
	output logic pvd_irq
);
	// ----------------------------------------------------------------
	// input synchronisers
	// ----------------------------------------------------------------
	localparam int NSYNC = 24 + 1 + lpm_pkg::BOR_LEVELS +
		lpm_pkg::PVD_LEVELS + 2;
	logic [NSYNC-1:0] sync1_r;
	logic [NSYNC-1:0] sync2_r;
	logic [NSYNC-1:0] async_in;
	lpm_pkg::lpm_wake_t wake_s;
	logic por_s;
	logic [lpm_pkg::BOR_LEVELS-1:0] bor_s;
	logic [lpm_pkg::PVD_LEVELS-1:0] pvd_s;
	logic [1:0] boot_s;

	assign async_in = {wake_src, por_low, bor_cmp, pvd_cmp, boot_pins};
	assign {wake_s, por_s, bor_s, pvd_s, boot_s} = sync2_r;

	// no reset here: cleared stages would read as a good supply and as
	// boot pins 00 at release, so they keep filling while rst is high
	always_ff @(posedge ref_clk) begin
		sync1_r <= async_in;
		sync2_r <= sync1_r;
	end

	// ----------------------------------------------------------------
	// slow oscillator tick and wake sampling
	// ----------------------------------------------------------------
	// the tick stands in for the always-on slow clock; keep SLOW_DIV
	// plus restart time under the wake budget
	logic [15:0] slow_cnt_r;
	logic slow_tick_r;
	lpm_pkg::lpm_wake_t wake_ls_r;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			slow_cnt_r <= '0;
			slow_tick_r <= 1'b0;
		end else if (slow_cnt_r == 16'(SLOW_DIV - 1)) begin
			slow_cnt_r <= '0;
			slow_tick_r <= 1'b1;
		end else begin
			slow_cnt_r <= slow_cnt_r + 16'h0001;
			slow_tick_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			wake_ls_r <= '0;
		else if (slow_tick_r)
			wake_ls_r <= wake_s;
	end

	// ----------------------------------------------------------------
	// registers
	// ----------------------------------------------------------------
	logic [lpm_pkg::CTRL_WIDTH-1:0] ctrl_r;
	logic [4:0] clkcfg_r;
	logic [23:0] wake_en_r;
	logic [23:0] wake_pend_r;
	logic pvd_flag_r;
	logic stby_flag_r;
	lpm_pkg::lpm_mode_t mode_r;
	lpm_pkg::lpm_mode_t mode_nxt;
	localparam int SEQ_W = lpm_pkg::SEQ_W;
	logic [SEQ_W-1:0] seq_cnt_r;
	logic pvd_out_r;
	logic wr_ctrl;
	logic wr_pvd;
	logic wr_pend;
	logic [1:0] vr_wr;

	assign wr_ctrl = reg_wr && reg_addr == lpm_pkg::OFS_CTRL;
	assign wr_pvd = reg_wr && reg_addr == lpm_pkg::OFS_PVD_FLAG;
	assign wr_pend = reg_wr && reg_addr == lpm_pkg::OFS_WAKE_PEND;
	assign vr_wr = reg_wdata[lpm_pkg::CTRL_VR_LSB +: 2];

	// core-domain registers are lost on supply reset and standby
	always_ff @(posedge ref_clk) begin
		if (rst || sys_reset) begin
			ctrl_r <= lpm_pkg::CTRL_RST;
			clkcfg_r <= lpm_pkg::CLK_RST;
		end else begin
			if (wr_ctrl) begin
				ctrl_r <= reg_wdata[lpm_pkg::CTRL_WIDTH-1:0];
				// range code 0 is not a range; keep the old one
				if (vr_wr == 2'h0)
					ctrl_r[lpm_pkg::CTRL_VR_LSB +: 2] <=
						ctrl_r[lpm_pkg::CTRL_VR_LSB +: 2];
			end
			if (reg_wr && reg_addr == lpm_pkg::OFS_CLK)
				clkcfg_r <= reg_wdata[4:0];
		end
	end

	// wake logic survives standby, only the pin reset clears it
	always_ff @(posedge ref_clk) begin
		if (rst)
			wake_en_r <= '0;
		else if (reg_wr && reg_addr == lpm_pkg::OFS_WAKE_EN)
			wake_en_r <= reg_wdata[23:0];
	end

	// ----------------------------------------------------------------
	// supply reset and brownout
	// ----------------------------------------------------------------
	logic [2:0] bor_sel;
	logic bor_below;
	assign bor_sel = (bor_level_opt >= 3'(lpm_pkg::BOR_LEVELS)) ?
		3'(lpm_pkg::BOR_LEVELS - 1) : bor_level_opt;
	assign bor_below = bor_s[bor_sel];

	always_ff @(posedge ref_clk) begin
		if (rst)
			sys_reset <= 1'b1;
		else
			sys_reset <= por_s || bor_below ||
				mode_r == lpm_pkg::M_STBY_EXIT;
	end

	// ----------------------------------------------------------------
	// voltage detector
	// ----------------------------------------------------------------
	logic [2:0] pvd_lvl;
	logic pvd_en;
	logic [1:0] pvd_edge;
	logic pvd_below;
	logic pvd_fall;
	logic pvd_rise;
	logic pvd_set;
	assign pvd_lvl = ctrl_r[lpm_pkg::CTRL_PVD_LVL_LSB +: 3] >
		3'(lpm_pkg::PVD_LEVELS - 1) ? 3'(lpm_pkg::PVD_LEVELS - 1) :
		ctrl_r[lpm_pkg::CTRL_PVD_LVL_LSB +: 3];
	assign pvd_en = ctrl_r[lpm_pkg::CTRL_PVD_EN];
	assign pvd_edge = ctrl_r[lpm_pkg::CTRL_PVD_EDGE_LSB +: 2];
	assign pvd_below = pvd_en && pvd_s[pvd_lvl];
	assign pvd_fall = pvd_below && !pvd_out_r;
	assign pvd_rise = !pvd_below && pvd_out_r;
	assign pvd_set = (pvd_edge[0] && pvd_fall) ||
		(pvd_edge[1] && pvd_rise);

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			pvd_out_r <= 1'b0;
			pvd_flag_r <= 1'b0;
			pvd_irq <= 1'b0;
		end else begin
			pvd_out_r <= pvd_below;
			// a crossing in the clearing cycle is kept
			if (pvd_set)
				pvd_flag_r <= 1'b1;
			else if (wr_pvd && reg_wdata[0])
				pvd_flag_r <= 1'b0;
			pvd_irq <= pvd_flag_r || pvd_set;
		end
	end

	// ----------------------------------------------------------------
	// wake qualification
	// ----------------------------------------------------------------
	logic vref_on;
	lpm_pkg::lpm_wake_t wake_raw;
	lpm_pkg::lpm_wake_t wake_hit;
	logic wake_any;
	assign vref_on = ctrl_r[lpm_pkg::CTRL_VREF_EN] &&
		!(ctrl_r[lpm_pkg::CTRL_VREF_AUTO] &&
		mode_r == lpm_pkg::M_STOP);

	always_comb begin
		wake_raw = wake_ls_r;
		wake_raw.supply_voltage_detector = pvd_out_r;
		wake_hit = wake_raw & lpm_pkg::lpm_wake_t'(wake_en_r);
		if (!vref_on) begin
			wake_hit.comp1 = 1'b0;
			wake_hit.comp2 = 1'b0;
		end
	end
	assign wake_any = |wake_hit;

	always_ff @(posedge ref_clk) begin
		if (rst)
			wake_pend_r <= '0;
		else if (slow_tick_r || wr_pend)
			// a hit in the clearing cycle stays pending
			wake_pend_r <= (wake_pend_r &
				~(wr_pend ? reg_wdata[23:0] : 24'h00_0000)) |
				(slow_tick_r ? 24'(wake_hit) : 24'h00_0000);
	end

	// ----------------------------------------------------------------
	// power mode sequencer
	// ----------------------------------------------------------------
	logic deep;
	always_comb begin
		deep = ctrl_r[lpm_pkg::CTRL_DEEP];
		mode_nxt = mode_r;
		case (mode_r)
			lpm_pkg::M_RUN, lpm_pkg::M_LP_RUN: begin
				if (core_sleep_req && deep && ctrl_r[lpm_pkg::CTRL_STBY])
					mode_nxt = lpm_pkg::M_STANDBY;
				else if (core_sleep_req && deep)
					mode_nxt = lpm_pkg::M_STOP;
				else if (core_sleep_req && (ctrl_r[lpm_pkg::CTRL_LPSLEEP] ||
						mode_r == lpm_pkg::M_LP_RUN))
					mode_nxt = lpm_pkg::M_LP_SLEEP;
				else if (core_sleep_req)
					mode_nxt = lpm_pkg::M_SLEEP;
				else if (ctrl_r[lpm_pkg::CTRL_LPRUN])
					mode_nxt = lpm_pkg::M_LP_RUN;
				else
					mode_nxt = lpm_pkg::M_RUN;
			end
			lpm_pkg::M_SLEEP: begin
				if (periph_evt || wake_any)
					mode_nxt = lpm_pkg::M_RUN;
			end
			lpm_pkg::M_LP_SLEEP: begin
				if (periph_evt || wake_any)
					mode_nxt = lpm_pkg::M_RUN;
			end
			lpm_pkg::M_STOP: begin
				if (wake_any)
					mode_nxt = lpm_pkg::M_STOP_EXIT;
			end
			lpm_pkg::M_STOP_EXIT: begin
				if (seq_cnt_r == SEQ_W'(OSC_RESTART_CYC - 1))
					mode_nxt = lpm_pkg::M_RUN;
			end
			lpm_pkg::M_STANDBY: begin
				if (wake_any)
					mode_nxt = lpm_pkg::M_STBY_EXIT;
			end
			lpm_pkg::M_STBY_EXIT: begin
				if (seq_cnt_r == SEQ_W'(lpm_pkg::RST_HOLD_CYC - 1))
					mode_nxt = lpm_pkg::M_RUN;
			end
			default: mode_nxt = lpm_pkg::M_RUN;
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (rst || (sys_reset && mode_r != lpm_pkg::M_STBY_EXIT))
			mode_r <= lpm_pkg::M_RUN;
		else
			mode_r <= mode_nxt;
	end

	always_ff @(posedge ref_clk) begin
		if (rst || mode_nxt != mode_r)
			seq_cnt_r <= '0;
		else if (seq_cnt_r != '1)
			seq_cnt_r <= seq_cnt_r + SEQ_W'(1);
	end

	always_ff @(posedge ref_clk) begin
		if (rst)
			stby_flag_r <= 1'b0;
		else if (mode_r == lpm_pkg::M_STANDBY)
			stby_flag_r <= 1'b1;
		else if (wr_ctrl && reg_wdata[31])
			stby_flag_r <= 1'b0;
	end

	// ----------------------------------------------------------------
	// clock, regulator and retention outputs
	// ----------------------------------------------------------------
	logic [1:0] vr;
	logic lp_mode;
	logic stopped;
	logic stby;
	assign vr = ctrl_r[lpm_pkg::CTRL_VR_LSB +: 2];
	assign lp_mode = mode_r == lpm_pkg::M_LP_RUN ||
		mode_r == lpm_pkg::M_LP_SLEEP;
	assign stopped = mode_r == lpm_pkg::M_STOP ||
		mode_r == lpm_pkg::M_STOP_EXIT;
	assign stby = mode_r == lpm_pkg::M_STANDBY ||
		mode_r == lpm_pkg::M_STBY_EXIT;

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			clk_ctl <= '0;
			reg_mode <= lpm_pkg::REG_MAIN;
			periph_limit <= 1'b0;
			ram_retain <= 1'b1;
			core_pwr_en <= 1'b1;
			internal_reference_voltage_en <= 1'b0;
		end else begin
			clk_ctl.cpu <= !(stopped || stby ||
				mode_r == lpm_pkg::M_SLEEP ||
				mode_r == lpm_pkg::M_LP_SLEEP);
			clk_ctl.core <= !(stopped || stby);
			clk_ctl.pll <= !(stopped || stby || lp_mode ||
				vr == lpm_pkg::VR3) &&
				clkcfg_r[lpm_pkg::CLK_SRC_LSB +: 2] == lpm_pkg::SRC_PLL;
			clk_ctl.multispeed_internal_osc <= !(stopped || stby);
			clk_ctl.fast_internal_osc <= !(stopped || stby || lp_mode);
			clk_ctl.fast_external_crystal <= !(stopped || stby ||
				lp_mode);
			clk_ctl.slow_osc <= 1'b1;
			if (stby)
				reg_mode <= lpm_pkg::REG_OFF;
			else if (lp_mode || stopped)
				reg_mode <= lpm_pkg::REG_LP;
			else
				reg_mode <= lpm_pkg::REG_MAIN;
			periph_limit <= lp_mode;
			ram_retain <= !stby;
			core_pwr_en <= !stby;
			internal_reference_voltage_en <= vref_on;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			sysclk_sel <= lpm_pkg::SRC_MSI;
			msi_range <= lpm_pkg::CLK_RST[lpm_pkg::CLK_MSI_LSB +: 3];
			cpu_fmax_mhz <= lpm_pkg::FMAX_VR2_MHZ;
			vcore_range <= lpm_pkg::VR2;
		end else begin
			vcore_range <= vr;
			if (lp_mode || vr == lpm_pkg::VR3)
				sysclk_sel <= lpm_pkg::SRC_MSI;
			else
				sysclk_sel <= lpm_pkg::lpm_src_t'(
					clkcfg_r[lpm_pkg::CLK_SRC_LSB +: 2]);
			if (lp_mode)
				msi_range <= lpm_pkg::MSI_MIN_RANGE;
			else
				msi_range <= clkcfg_r[lpm_pkg::CLK_MSI_LSB +: 3];
			case (vr)
				lpm_pkg::VR1: cpu_fmax_mhz <= lpm_pkg::FMAX_VR1_MHZ;
				lpm_pkg::VR3: cpu_fmax_mhz <= lpm_pkg::FMAX_VR3_MHZ;
				default: cpu_fmax_mhz <= lpm_pkg::FMAX_VR2_MHZ;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// boot strap
	// ----------------------------------------------------------------
	logic boot_take_r;
	always_ff @(posedge ref_clk) begin
		if (rst || sys_reset) begin
			boot_take_r <= 1'b1;
		end else if (boot_take_r) begin
			boot_take_r <= 1'b0;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			boot_src <= lpm_pkg::BOOT_FLASH;
			loader_port_en <= '0;
		end else if (boot_take_r && !sys_reset) begin
			if (!boot_s[0])
				boot_src <= lpm_pkg::BOOT_FLASH;
			else if (!boot_s[1])
				boot_src <= lpm_pkg::BOOT_SYSMEM;
			else
				boot_src <= lpm_pkg::BOOT_SRAM;
			loader_port_en <= (boot_s == 2'h1) ? 3'h7 : 3'h0;
		end
	end

	// ----------------------------------------------------------------
	// register read port
	// ----------------------------------------------------------------
	always_ff @(posedge ref_clk) begin
		if (rst) begin
			reg_rdata <= '0;
		end else if (reg_rd) begin
			case (reg_addr)
				lpm_pkg::OFS_CTRL: reg_rdata <= 32'(ctrl_r);
				lpm_pkg::OFS_CLK: reg_rdata <= 32'(clkcfg_r);
				lpm_pkg::OFS_WAKE_EN: reg_rdata <= 32'(wake_en_r);
				lpm_pkg::OFS_STATUS: reg_rdata <= 32'({stby_flag_r, vr,
					pvd_out_r, boot_src, reg_mode, mode_r});
				lpm_pkg::OFS_PVD_FLAG: reg_rdata <= 32'(pvd_flag_r);
				lpm_pkg::OFS_WAKE_PEND: reg_rdata <= 32'(wake_pend_r);
				default: reg_rdata <= 32'h0000_0000;
			endcase
		end else begin
			reg_rdata <= 32'h0000_0000;
		end
	end

	// ----------------------------------------------------------------
	// checks
	// ----------------------------------------------------------------
	logic [SEQ_W-1:0] exit_cnt_r;
	always_ff @(posedge ref_clk) begin
		if (rst || mode_r != lpm_pkg::M_STOP_EXIT)
			exit_cnt_r <= '0;
		else
			exit_cnt_r <= exit_cnt_r + SEQ_W'(1);
	end

	fmax_range_a: assert property (@(posedge ref_clk) disable iff (rst)
		vr == lpm_pkg::VR3 |=> cpu_fmax_mhz == lpm_pkg::FMAX_VR3_MHZ)
		else $error("range three clock cap wrong");
	vr3_msi_a: assert property (@(posedge ref_clk) disable iff (rst)
		vr == lpm_pkg::VR3 |=> sysclk_sel == lpm_pkg::SRC_MSI)
		else $error("range three not on multispeed oscillator");
	sleep_cpu_a: assert property (@(posedge ref_clk) disable iff (rst)
		mode_r == lpm_pkg::M_SLEEP |=> !clk_ctl.cpu && clk_ctl.core)
		else $error("sleep clock gating wrong");
	lprun_min_a: assert property (@(posedge ref_clk) disable iff (rst)
		mode_r == lpm_pkg::M_LP_RUN |=>
		msi_range == lpm_pkg::MSI_MIN_RANGE && reg_mode == lpm_pkg::REG_LP)
		else $error("low-power run setup wrong");
	lpsleep_wake_a: assert property (@(posedge ref_clk) disable iff
		(rst || sys_reset) mode_r == lpm_pkg::M_LP_SLEEP && periph_evt |=>
		mode_r == lpm_pkg::M_RUN ##1 reg_mode == lpm_pkg::REG_MAIN)
		else $error("low-power sleep wake wrong");
	stop_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		mode_r == lpm_pkg::M_STOP |=> !clk_ctl.core && !clk_ctl.pll &&
		!clk_ctl.fast_external_crystal && clk_ctl.slow_osc && ram_retain)
		else $error("stop gating wrong");
	stop_exit_a: assert property (@(posedge ref_clk) disable iff (rst)
		exit_cnt_r <= SEQ_W'(lpm_pkg::WAKE_CYC))
		else $error("stop exit too slow");
	comp_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
		!vref_on |-> !wake_hit.comp1 && !wake_hit.comp2)
		else $error("comparator wake without reference");
	supply_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		por_s |=> sys_reset ##1 mode_r == lpm_pkg::M_RUN)
		else $error("supply reset not held");
	pvd_fall_a: assert property (@(posedge ref_clk) disable iff (rst)
		pvd_edge[0] && pvd_fall |=> pvd_flag_r && pvd_irq)
		else $error("detector fall not flagged");
	pvd_off_a: assert property (@(posedge ref_clk) disable iff (rst)
		!pvd_en |=> !pvd_out_r)
		else $error("detector active while disabled");
	stby_reg_a: assert property (@(posedge ref_clk) disable iff (rst)
		mode_r == lpm_pkg::M_STANDBY |=> reg_mode == lpm_pkg::REG_OFF &&
		!core_pwr_en)
		else $error("standby regulator wrong");
	boot_hold_a: assert property (@(posedge ref_clk) disable iff (rst)
		!boot_take_r && !sys_reset |=> $stable(boot_src))
		else $error("boot source changed after reset");
endmodule : lpm_ctrl

`default_nettype wire

/* tb/lpm_core_model.sv */
// Purpose: core side of the controller: sleep requests, peripheral events
// Assumes: same clock as the controller
// Notes: the bench drives it through its tasks
`timescale 1ns/1ns
`default_nettype none
module lpm_core_model (
	input wire logic ref_clk,
	output logic core_sleep_req,
	output logic periph_evt
);
	initial begin
		core_sleep_req = 1'b0;
		periph_evt = 1'b0;
	end
	// one-cycle wait-for-interrupt pulse
	task sleep;
		@(posedge ref_clk);
		core_sleep_req <= 1'b1;
		@(posedge ref_clk);
		core_sleep_req <= 1'b0;
	endtask : sleep
	// event level stays up until dropped, as a pending peripheral irq does
	task evt(input logic v);
		@(posedge ref_clk);
		periph_evt <= v;
	endtask : evt
endmodule : lpm_core_model
`default_nettype wire

/* tb/testbench.sv */
// Purpose: self-checking bench of the low-power mode controller
// Assumes: short slow tick and oscillator restart keep the run brief
// Notes: wake budget is counted in status polls of two cycles each
`timescale 1ns/1ns
`default_nettype none
module testbench;
	typedef struct packed {
		logic [1:0] vr;
		logic [5:0] fm;
		logic [1:0] src;
	} lpm_row_t;
	lpm_row_t rows [3] = '{'{lpm_pkg::VR1, lpm_pkg::FMAX_VR1_MHZ, 2'h1},
		'{lpm_pkg::VR2, lpm_pkg::FMAX_VR2_MHZ, 2'h1},
		'{lpm_pkg::VR3, lpm_pkg::FMAX_VR3_MHZ, 2'h0}};
	logic ref_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic por_low = 1'b0, core_sleep_req, periph_evt, periph_limit;
	logic ram_retain, core_pwr_en, internal_reference_voltage_en, sys_reset, pvd_irq;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata, s;
	lpm_pkg::lpm_wake_t wake_src = '0;
	logic [4:0] bor_cmp = 5'h00;
	logic [2:0] bor_level_opt = 3'h2, msi_range, loader_port_en;
	logic [6:0] pvd_cmp = 7'h00;
	logic [1:0] boot_pins = 2'h1, vcore_range;
	lpm_pkg::lpm_clk_ctl_t clk_ctl;
	lpm_pkg::lpm_src_t sysclk_sel;
	logic [5:0] cpu_fmax_mhz;
	lpm_pkg::lpm_reg_t reg_mode;
	lpm_pkg::lpm_boot_t boot_src;
	int mismatches = 0;
	int total_checks = 0;
	always #2 ref_clk = ~ref_clk;
	lpm_ctrl #(.SLOW_DIV(4), .OSC_RESTART_CYC(2)) lpm_ctrl_inst (.ref_clk,
		.rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
		.core_sleep_req, .periph_evt, .wake_src, .por_low, .bor_cmp,
		.bor_level_opt, .pvd_cmp, .boot_pins, .clk_ctl, .sysclk_sel,
		.msi_range, .cpu_fmax_mhz, .vcore_range, .reg_mode, .periph_limit,
		.ram_retain, .core_pwr_en, .internal_reference_voltage_en, .sys_reset, .boot_src,
		.loader_port_en, .pvd_irq);
	lpm_core_model lpm_core_model_inst (.ref_clk, .core_sleep_req,
		.periph_evt);
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		total_checks++;
		if (seen !== exp) begin
			mismatches++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : chk
	task print_verdict;
		$display("mismatches=%0d checks=%0d", mismatches, total_checks);
		if (mismatches == 0 && total_checks > 0) $display("verification passed");
		else $display("verification failed");
		$finish;
	endtask : print_verdict
	task wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge ref_clk);
		reg_wr <= 1'b0;
	endtask : wr
	task rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge ref_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge ref_clk);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask : rd
	task cyc(input int n);
		repeat (n) @(posedge ref_clk);
		#1;
	endtask : cyc
	task mode_is(input logic [2:0] m);
		rd(lpm_pkg::OFS_STATUS, s);
		chk({29'h0, s[2:0]}, {29'h0, m});
	endtask : mode_is
	// polls cost two cycles, so the loop bound is the whole wake budget
	task wait_run;
		for (int i = 0; i < lpm_pkg::WAKE_CYC / 2; i++) begin
			rd(lpm_pkg::OFS_STATUS, s);
			if (s[2:0] === lpm_pkg::M_RUN) return;
		end
		mismatches++;
		print_verdict();
	endtask : wait_run
	task wait_rel;
		for (int i = 0; i < 50; i++) begin
			cyc(1);
			if (sys_reset === 1'b0) return;
		end
		mismatches++;
		print_verdict();
	endtask : wait_rel
	task stop_wake;
		lpm_core_model_inst.sleep();
		cyc(3);
	endtask : stop_wake
	// ----
	// stimulus
	// ----
	initial begin
		repeat (10) @(posedge ref_clk);
		rst <= 1'b0;
		wait_rel();
		cyc(2);
		chk({30'h0, boot_src}, 32'h1);
		chk({29'h0, loader_port_en}, 32'h7);
		rd(lpm_pkg::OFS_CTRL, s);
		chk(s, 32'h82);
		rd(8'h3C, s);
		chk(s, 32'h0);
		wr(lpm_pkg::OFS_CLK, 32'h15);
		for (int i = 0; i < 3; i++) begin
			wr(lpm_pkg::OFS_CTRL, {30'h20, rows[i].vr});
			cyc(3);
			chk({26'h0, cpu_fmax_mhz}, {26'h0, rows[i].fm});
			chk({30'h0, vcore_range}, {30'h0, rows[i].vr});
			chk({30'h0, sysclk_sel}, {30'h0, rows[i].src});
		end
		wr(lpm_pkg::OFS_CTRL, 32'h82);
		stop_wake();
		chk({30'h0, clk_ctl.cpu, clk_ctl.core}, 32'h1);
		mode_is(lpm_pkg::M_SLEEP);
		lpm_core_model_inst.evt(1'b1);
		cyc(3);
		mode_is(lpm_pkg::M_RUN);
		lpm_core_model_inst.evt(1'b0);
		wr(lpm_pkg::OFS_CTRL, 32'h8A);
		stop_wake();
		mode_is(lpm_pkg::M_LP_SLEEP);
		chk({30'h0, reg_mode}, 32'h1);
		lpm_core_model_inst.evt(1'b1);
		cyc(3);
		mode_is(lpm_pkg::M_RUN);
		chk({30'h0, reg_mode}, 32'h0);
		lpm_core_model_inst.evt(1'b0);
		wr(lpm_pkg::OFS_CTRL, 32'h92);
		cyc(3);
		mode_is(lpm_pkg::M_LP_RUN);
		chk({29'h0, msi_range}, {29'h0, lpm_pkg::MSI_MIN_RANGE});
		chk({31'h0, periph_limit}, 32'h1);
		chk({30'h0, reg_mode}, 32'h1);
		wr(lpm_pkg::OFS_WAKE_EN, 32'h20020);
		wr(lpm_pkg::OFS_CTRL, 32'h06);
		stop_wake();
		chk({25'h0, clk_ctl}, 32'h1);
		chk({31'h0, ram_retain}, 32'h1);
		chk({30'h0, reg_mode}, 32'h1);
		@(posedge ref_clk);
		wake_src.comp1 <= 1'b1;
		cyc(40);
		mode_is(lpm_pkg::M_STOP);
		@(posedge ref_clk);
		wake_src.ext[5] <= 1'b1;
		wait_run();
		mode_is(lpm_pkg::M_RUN);
		@(posedge ref_clk);
		wake_src <= '0;
		wr(lpm_pkg::OFS_WAKE_PEND, 32'hFFFFFF);
		wr(lpm_pkg::OFS_CTRL, 32'hC6);
		stop_wake();
		chk({31'h0, internal_reference_voltage_en}, 32'h0);
		@(posedge ref_clk);
		wake_src.ext[5] <= 1'b1;
		wait_run();
		chk({31'h0, internal_reference_voltage_en}, 32'h1);
		@(posedge ref_clk);
		wake_src <= '0;
		wr(lpm_pkg::OFS_CTRL, 32'h26);
		cyc(8);
		stop_wake();
		chk({30'h0, core_pwr_en, ram_retain}, 32'h0);
		chk({30'h0, reg_mode}, 32'h2);
		@(posedge ref_clk);
		wake_src.ext[5] <= 1'b1;
		wait_run();
		cyc(2);
		chk({31'h0, core_pwr_en}, 32'h1);
		rd(lpm_pkg::OFS_STATUS, s);
		chk({31'h0, s[10]}, 32'h1);
		rd(lpm_pkg::OFS_CTRL, s);
		chk(s, 32'h82);
		rd(lpm_pkg::OFS_WAKE_EN, s);
		chk(s, 32'h20020);
		// level 3 falling, then rising
		wr(lpm_pkg::OFS_CTRL, 32'h1782);
		@(posedge ref_clk);
		pvd_cmp <= 7'h07;
		cyc(8);
		chk({31'h0, pvd_irq}, 32'h0);
		@(posedge ref_clk);
		pvd_cmp <= 7'h0F;
		cyc(8);
		chk({31'h0, pvd_irq}, 32'h1);
		wr(lpm_pkg::OFS_PVD_FLAG, 32'h1);
		wr(lpm_pkg::OFS_CTRL, 32'h2782);
		cyc(3);
		chk({31'h0, pvd_irq}, 32'h0);
		@(posedge ref_clk);
		pvd_cmp <= 7'h07;
		cyc(8);
		chk({31'h0, pvd_irq}, 32'h1);
		wr(lpm_pkg::OFS_PVD_FLAG, 32'h1);
		wr(lpm_pkg::OFS_CTRL, 32'h0782);
		@(posedge ref_clk);
		pvd_cmp <= 7'h0F;
		cyc(8);
		chk({31'h0, pvd_irq}, 32'h0);
		@(posedge ref_clk);
		pvd_cmp <= 7'h07;
		cyc(8);
		wr(lpm_pkg::OFS_CTRL, 32'h1682);
		@(posedge ref_clk);
		pvd_cmp <= 7'h0F;
		cyc(8);
		chk({31'h0, pvd_irq}, 32'h0);
		@(posedge ref_clk);
		boot_pins <= 2'h3;
		bor_cmp <= 5'h02;
		cyc(6);
		chk({30'h0, boot_src}, 32'h1);
		chk({31'h0, sys_reset}, 32'h0);
		@(posedge ref_clk);
		bor_cmp <= 5'h04;
		cyc(6);
		chk({31'h0, sys_reset}, 32'h1);
		@(posedge ref_clk);
		bor_level_opt <= 3'h6;
		cyc(6);
		chk({31'h0, sys_reset}, 32'h0);
		@(posedge ref_clk);
		bor_cmp <= 5'h10;
		cyc(6);
		chk({31'h0, sys_reset}, 32'h1);
		@(posedge ref_clk);
		bor_cmp <= 5'h00;
		por_low <= 1'b1;
		cyc(6);
		chk({31'h0, sys_reset}, 32'h1);
		@(posedge ref_clk);
		por_low <= 1'b0;
		wait_rel();
		cyc(2);
		chk({30'h0, boot_src}, 32'h2);
		chk({29'h0, loader_port_en}, 32'h0);
		print_verdict();
	end
endmodule : testbench
`default_nettype wire
